// *** logic/deac_array.sv ***
// Nonvolatile data array block reached through four special function registers.
// Assumes register accesses are synchronous single-cycle strokes from the core.
// How it works
// - 64-byte array, byte granular access.
// - Each write erases then programs the byte.
// - Internal timer sets write duration.
// - Upper two address bits decoded on reads only (writes ignore them), keep zero.
// - Control bits 7 to 5 read zero.
// - Write end clears launch, sets done flag.
// - External or watchdog reset during write sets abort flag.
// - Address and data survive aborting reset.
// - Write permit cleared at power-up.
// - Launch bits only settable; hardware clears them.
// - Read loads data register next cycle.
// - Data register holds until read or write.
// - Key port stores nothing, reads zero.
// - Write needs 55h, AAh, then launch.
// - Launch ignored while permit is zero.
// - Clearing permit never stops running write.
// - Hardware clears the permit bit only on reset.
// - Software loads address and data first.
// - Software masks interrupts during unlock.
// - Software keeps permit clear when idle; the core leaves permit set after a write.
// - Core access unaffected by code protection.
// - Writes blocked during power-up delay.
`timescale 1ns/10ps
`default_nettype none
module deac_array #(
  parameter int unsigned POWERUP_WAIT = deac_pkg::POWERUP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic code_protect_i,
  deac_sfr_if.device sfr,
  output logic write_busy_o,
  output logic programmer_block_o
);
  import deac_pkg::*;

  logic [7:0] mem [ARRAY_DEPTH];
  logic [7:0] nv_address_reg;
  logic [7:0] nv_data_reg;
  logic read_launch_reg;
  logic write_launch_reg;
  logic write_permit_reg;
  logic write_abort_reg;
  logic write_done_reg;
  logic [31:0] powerup_reg;
  logic [15:0] timer_reg;
  logic [5:0] wr_index_reg;
  logic [7:0] wr_value_reg;
  deac_wstate_e wstate_reg;
  deac_key_e key_reg;
  logic sync_reset;
  logic ctrl_wr;
  logic key_wr;
  logic start_write;
  logic write_finish;
  logic powerup_busy;

  function automatic logic hits(input logic [7:0] a, input logic [7:0] target);
    hits = (a == target);
  endfunction : hits

  assign sync_reset = sfr.ext_reset | sfr.wdt_reset;
  assign ctrl_wr = sfr.wr_en && hits(sfr.addr, NV_CONTROL_STATUS_ADDR);
  assign key_wr = sfr.wr_en && hits(sfr.addr, UNLOCK_KEY_PORT_ADDR);
  assign powerup_busy = (powerup_reg != 32'h0);
  // The launch is honoured only with permit set, key armed and no write running.
  assign start_write = ctrl_wr && sfr.wdata[WRITE_LAUNCH_BIT] && write_permit_reg
    && (key_reg == DEAC_K_ARMED) && !powerup_busy && (wstate_reg == DEAC_W_IDLE);
  assign write_finish = (wstate_reg == DEAC_W_PROG) && (timer_reg == 16'h0);
  assign write_busy_o = write_launch_reg;
  // Core access ignores code protection; only the programmer path is gated.
  assign programmer_block_o = code_protect_i;

  // Only power-on primes the wait; the external and watchdog resets leave it alone.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      powerup_reg <= 32'(POWERUP_WAIT);
    end else if (ce_i && powerup_busy) begin
      powerup_reg <= powerup_reg - 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      key_reg <= DEAC_K_IDLE;
    end else if (ce_i) begin
      if (sync_reset) begin
        key_reg <= DEAC_K_IDLE;
      end else if (sfr.wr_en || sfr.rd_en) begin
        case (key_reg)
          DEAC_K_IDLE: key_reg <= (key_wr && sfr.wdata == UNLOCK_KEY_FIRST) ? DEAC_K_FIRST
                                  : DEAC_K_IDLE;
          DEAC_K_FIRST: key_reg <= (key_wr && sfr.wdata == UNLOCK_KEY_SECOND) ? DEAC_K_ARMED
                                   : DEAC_K_IDLE;
          default: key_reg <= DEAC_K_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wstate_reg <= DEAC_W_IDLE;
      timer_reg <= 16'h0;
      wr_index_reg <= 6'h0;
      wr_value_reg <= 8'h0;
    end else if (ce_i) begin
      if (sync_reset) begin
        wstate_reg <= DEAC_W_IDLE;
      end else begin
        case (wstate_reg)
          DEAC_W_IDLE: if (start_write) begin
            wstate_reg <= DEAC_W_ERASE;
            timer_reg <= 16'(ERASE_CYCLES - 1);
            wr_index_reg <= nv_address_reg[5:0];
            wr_value_reg <= nv_data_reg;
          end
          DEAC_W_ERASE: if (timer_reg == 16'h0) begin
            wstate_reg <= DEAC_W_PROG;
            timer_reg <= 16'(PROGRAM_CYCLES - 1);
          end else begin
            timer_reg <= timer_reg - 16'h1;
          end
          DEAC_W_PROG: if (timer_reg == 16'h0) begin
            wstate_reg <= DEAC_W_IDLE;
          end else begin
            timer_reg <= timer_reg - 16'h1;
          end
          default: wstate_reg <= DEAC_W_IDLE;
        endcase
      end
    end
  end

  // The array is nonvolatile, so it has no reset; erase writes all ones first.
  always_ff @(posedge clk_i) begin
    if (ce_i && !sync_reset) begin
      if (wstate_reg == DEAC_W_ERASE && timer_reg == 16'h0) begin
        mem[wr_index_reg] <= 8'hff;
      end else if (write_finish) begin
        mem[wr_index_reg] <= wr_value_reg;
      end
    end
  end

  // Address and data are not touched by the external or watchdog reset.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nv_address_reg <= NV_REG_RESET;
      nv_data_reg <= NV_REG_RESET;
    end else if (ce_i) begin
      if (sfr.wr_en && hits(sfr.addr, NV_ADDRESS_ADDR)) begin
        nv_address_reg <= sfr.wdata;
      end
      if (read_launch_reg) begin
        nv_data_reg <= (nv_address_reg <= ARRAY_LAST) ? mem[nv_address_reg[5:0]] : 8'h00;
      end else if (sfr.wr_en && hits(sfr.addr, NV_DATA_ADDR)) begin
        nv_data_reg <= sfr.wdata;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      read_launch_reg <= 1'b0;
      write_launch_reg <= 1'b0;
      write_permit_reg <= 1'b0;
      write_abort_reg <= 1'b0;
      write_done_reg <= 1'b0;
    end else if (ce_i) begin
      if (sync_reset) begin
        read_launch_reg <= 1'b0;
        write_launch_reg <= 1'b0;
        write_permit_reg <= 1'b0;
        write_abort_reg <= write_abort_reg | (wstate_reg != DEAC_W_IDLE);
      end else begin
        if (ctrl_wr && sfr.wdata[READ_LAUNCH_BIT]) begin
          read_launch_reg <= 1'b1;
        end else if (read_launch_reg) begin
          read_launch_reg <= 1'b0;
        end
        if (start_write) begin
          write_launch_reg <= 1'b1;
        end else if (write_finish) begin
          write_launch_reg <= 1'b0;
        end
        if (ctrl_wr) begin
          write_permit_reg <= sfr.wdata[WRITE_PERMIT_BIT];
          write_abort_reg <= sfr.wdata[WRITE_ABORT_BIT];
        end
        if (write_finish) begin
          write_done_reg <= 1'b1;
        end else if (ctrl_wr) begin
          write_done_reg <= sfr.wdata[WRITE_DONE_BIT];
        end
      end
    end
  end

  always_comb begin
    sfr.rdata = 8'h00;
    if (hits(sfr.addr, NV_DATA_ADDR)) begin
      sfr.rdata = nv_data_reg;
    end else if (hits(sfr.addr, NV_ADDRESS_ADDR)) begin
      sfr.rdata = nv_address_reg;
    end else if (hits(sfr.addr, NV_CONTROL_STATUS_ADDR)) begin
      sfr.rdata = {3'h0, write_done_reg, write_abort_reg, write_permit_reg,
                   write_launch_reg, read_launch_reg};
    end
  end
endmodule : deac_array
`default_nettype wire

// *** logic/deac_pkg.sv ***
// Package for the nonvolatile data array access block and its register-side master.
// Assumes a single 200 MHz clock shared by both ends.
package deac_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned ARRAY_DEPTH = 64;
  localparam logic [7:0] ARRAY_LAST = 8'h3f;
  // Register addresses on the special function register port.
  localparam logic [7:0] NV_DATA_ADDR = 8'h08;
  localparam logic [7:0] NV_ADDRESS_ADDR = 8'h09;
  localparam logic [7:0] NV_CONTROL_STATUS_ADDR = 8'h88;
  localparam logic [7:0] UNLOCK_KEY_PORT_ADDR = 8'h89;
  // Control/status field positions.
  localparam int unsigned READ_LAUNCH_BIT = 0;
  localparam int unsigned WRITE_LAUNCH_BIT = 1;
  localparam int unsigned WRITE_PERMIT_BIT = 2;
  localparam int unsigned WRITE_ABORT_BIT = 3;
  localparam int unsigned WRITE_DONE_BIT = 4;
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;
  localparam logic [7:0] NV_REG_RESET = 8'h00;
  // Self-timed write: erase phase then program phase.
  localparam int unsigned ERASE_TIME_NS = 2000;
  localparam int unsigned PROGRAM_TIME_NS = 2000;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PROGRAM_CYCLES = PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_TIME_MS = 72;
  localparam int unsigned POWERUP_CYCLES = POWERUP_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // Master command register map (APB side).
  localparam logic [7:0] CMD_ADDR_OFS = 8'h00;
  localparam logic [7:0] CMD_DATA_OFS = 8'h04;
  localparam logic [7:0] CMD_CTRL_OFS = 8'h08;
  localparam logic [7:0] CMD_STAT_OFS = 8'h0c;
  localparam logic [7:0] CMD_RDATA_OFS = 8'h10;
  localparam int unsigned CMD_GO_READ_BIT = 0;
  localparam int unsigned CMD_GO_WRITE_BIT = 1;
  localparam int unsigned CMD_PERMIT_BIT = 2;
  localparam int unsigned CMD_CLR_DONE_BIT = 3;
  typedef enum logic [2:0] {
    DEAC_W_IDLE = 3'b000, DEAC_W_ERASE = 3'b001, DEAC_W_PROG = 3'b011
  } deac_wstate_e;
  typedef enum logic [1:0] {
    DEAC_K_IDLE = 2'b00, DEAC_K_FIRST = 2'b01, DEAC_K_ARMED = 2'b11
  } deac_key_e;
endpackage : deac_pkg

// *** logic/deac_sfr_if.sv ***
// Special function register port between the core-side master and the array block.
// Assumes both ends share one clock; one access per cycle, no wait states.
`timescale 1ns/10ps
`default_nettype none
interface deac_sfr_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ext_reset;
  logic wdt_reset;
  modport device (input wr_en, rd_en, addr, wdata, ext_reset, wdt_reset, output rdata);
  modport core (output wr_en, rd_en, addr, wdata, ext_reset, wdt_reset, input rdata);
endinterface : deac_sfr_if
`default_nettype wire

// *** logic/deac_core.sv ***
// Core-side master: APB slave registers turned into special function register strokes.
// Assumes the array block sits on the same clock across deac_sfr_if.
`timescale 1ns/10ps
`default_nettype none
module deac_core (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext_reset_i,
  input wire logic wdt_reset_i,
  deac_sfr_if.core sfr
);
  import deac_pkg::*;

  // Each command is one sequence of register strokes, played out one per cycle.
  logic [7:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] rdata_reg;
  logic [2:0] step_reg;
  logic [1:0] op_reg;
  logic apb_wr;
  logic busy;

  assign apb_wr = psel_i && penable_i && pwrite_i && ce_i;
  assign busy = (op_reg != 2'h0);
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign sfr.ext_reset = ext_reset_i;
  assign sfr.wdt_reset = wdt_reset_i;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
    end else if (apb_wr && paddr_i == CMD_ADDR_OFS) begin
      addr_reg <= pwdata_i[7:0];
    end else if (apb_wr && paddr_i == CMD_DATA_OFS) begin
      data_reg <= pwdata_i[7:0];
    end
  end

  // op 1 read, 2 write, 3 permit/flag update.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_reg <= 2'h0;
      step_reg <= 3'h0;
    end else if (ce_i) begin
      if (!busy && apb_wr && paddr_i == CMD_CTRL_OFS) begin
        op_reg <= pwdata_i[CMD_GO_WRITE_BIT] ? 2'h2 : pwdata_i[CMD_GO_READ_BIT] ? 2'h1 : 2'h3;
        step_reg <= 3'h0;
      end else if (busy) begin
        step_reg <= step_reg + 3'h1;
        if ((op_reg == 2'h1 && step_reg == 3'h3) || (op_reg == 2'h2 && step_reg == 3'h5)
            || (op_reg == 2'h3 && step_reg == 3'h0)) begin
          op_reg <= 2'h0;
        end
      end
    end
  end

  logic permit_reg;
  logic clr_done_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      permit_reg <= 1'b0;
      clr_done_reg <= 1'b0;
    end else if (!busy && apb_wr && paddr_i == CMD_CTRL_OFS) begin
      permit_reg <= pwdata_i[CMD_PERMIT_BIT];
      clr_done_reg <= pwdata_i[CMD_CLR_DONE_BIT];
    end
  end

  logic [7:0] ctrl_word;
  // Every control stroke rewrites all bits, so the done flag is carried over unless cleared.
  assign ctrl_word = {3'h0, sfr.rdata[WRITE_DONE_BIT] && !clr_done_reg, 1'b0, permit_reg, 2'b00};

  always_comb begin
    sfr.wr_en = 1'b0;
    sfr.rd_en = 1'b0;
    sfr.addr = 8'h00;
    sfr.wdata = 8'h00;
    case ({op_reg, step_reg})
      {2'h1, 3'h0}, {2'h2, 3'h0}: begin
        sfr.wr_en = 1'b1;
        sfr.addr = NV_ADDRESS_ADDR;
        sfr.wdata = addr_reg;
      end
      {2'h2, 3'h1}: begin
        sfr.wr_en = 1'b1;
        sfr.addr = NV_DATA_ADDR;
        sfr.wdata = data_reg;
      end
      {2'h2, 3'h3}: begin
        sfr.wr_en = 1'b1;
        sfr.addr = UNLOCK_KEY_PORT_ADDR;
        sfr.wdata = UNLOCK_KEY_FIRST;
      end
      {2'h2, 3'h4}: begin
        sfr.wr_en = 1'b1;
        sfr.addr = UNLOCK_KEY_PORT_ADDR;
        sfr.wdata = UNLOCK_KEY_SECOND;
      end
      {2'h2, 3'h5}: begin
        sfr.wr_en = 1'b1;
        sfr.addr = NV_CONTROL_STATUS_ADDR;
        sfr.wdata = ctrl_word | 8'h02;
      end
      // The permit must already be set when the launch stroke arrives, so it goes first.
      {2'h1, 3'h1}, {2'h3, 3'h0}, {2'h2, 3'h2}: begin
        sfr.wr_en = 1'b1;
        sfr.addr = NV_CONTROL_STATUS_ADDR;
        sfr.wdata = ctrl_word | ((op_reg == 2'h1) ? 8'h01 : 8'h00);
      end
      {2'h1, 3'h3}: begin
        sfr.rd_en = 1'b1;
        sfr.addr = NV_DATA_ADDR;
      end
      default: begin
        sfr.addr = NV_CONTROL_STATUS_ADDR;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= 8'h00;
    end else if (ce_i && sfr.rd_en) begin
      rdata_reg <= sfr.rdata;
    end
  end

  always_comb begin
    prdata_o = 32'h0;
    if (paddr_i == CMD_ADDR_OFS) begin
      prdata_o = {24'h0, addr_reg};
    end else if (paddr_i == CMD_DATA_OFS) begin
      prdata_o = {24'h0, data_reg};
    end else if (paddr_i == CMD_STAT_OFS) begin
      prdata_o = {23'h0, busy, (busy ? 8'h00 : sfr.rdata)};
    end else if (paddr_i == CMD_RDATA_OFS) begin
      prdata_o = {24'h0, rdata_reg};
    end
  end
endmodule : deac_core
`default_nettype wire

// *** verification/deac_array_properties.sv ***
// Concurrent checks on the register port between the core-side master and the array block.
// Assumes one clock and that write_busy_o mirrors the write-launch bit.
`timescale 1ns/10ps
`default_nettype none
module deac_array_properties
  import deac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ext_reset,
  input wire logic wdt_reset,
  input wire logic write_busy_o
);
  logic k1_reg, k2_reg, abrt_reg, have_reg, dirty_reg;
  logic [11:0] cnt_reg;
  logic [7:0] last_reg;
  logic ctrl_wr, key_wr, ctrl_rd, data_rd;
  assign ctrl_wr = wr_en && addr == NV_CONTROL_STATUS_ADDR;
  assign key_wr = wr_en && addr == UNLOCK_KEY_PORT_ADDR;
  // Read data is combinational, so the control register is on view whenever addressed.
  assign ctrl_rd = !wr_en && addr == NV_CONTROL_STATUS_ADDR;
  assign data_rd = rd_en && addr == NV_DATA_ADDR;
  // Only strokes advance the tracker; idle cycles between them leave it alone.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      k1_reg <= 1'b0;
      k2_reg <= 1'b0;
    end else if (ext_reset || wdt_reset) begin
      k1_reg <= 1'b0;
      k2_reg <= 1'b0;
    end else if (wr_en || rd_en) begin
      k1_reg <= key_wr && wdata == UNLOCK_KEY_FIRST;
      k2_reg <= k1_reg && key_wr && wdata == UNLOCK_KEY_SECOND;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 12'h000;
      abrt_reg <= 1'b0;
    end else begin
      cnt_reg <= write_busy_o ? cnt_reg + 12'h001 : 12'h000;
      abrt_reg <= write_busy_o && (abrt_reg || ext_reset || wdt_reset);
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      have_reg <= 1'b0;
      dirty_reg <= 1'b0;
      last_reg <= 8'h00;
    end else if (data_rd) begin
      have_reg <= 1'b1;
      dirty_reg <= 1'b0;
      last_reg <= rdata;
    end else if ((wr_en && addr == NV_DATA_ADDR) || (ctrl_wr && wdata[0])) begin
      dirty_reg <= 1'b1;
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_ctrl_upper_zero: assert property (ctrl_rd |-> rdata[7:5] == 3'h0)
    else $error("control upper bits not zero");
  a_key_reads_zero: assert property (rd_en && addr == UNLOCK_KEY_PORT_ADDR |-> rdata == 8'h00)
    else $error("key port read not zero");
  a_launch_bit_busy: assert property (ctrl_rd |-> rdata[1] == write_busy_o)
    else $error("launch bit differs from busy");
  a_busy_needs_key: assert property ($rose(write_busy_o) |-> $past(ctrl_wr && wdata[1] && k2_reg))
    else $error("write started without unlock");
  a_reset_stops_write: assert property (write_busy_o && (ext_reset || wdt_reset) |-> ##[1:2] !write_busy_o)
    else $error("reset did not stop write");
  a_busy_len_max: assert property (cnt_reg <= 12'd820)
    else $error("write cycle too long");
  a_busy_len_min: assert property ($fell(write_busy_o) && !abrt_reg |-> cnt_reg >= 12'd780)
    else $error("write cycle too short");
  a_data_holds: assert property (data_rd && have_reg && !dirty_reg |-> rdata == last_reg)
    else $error("data register changed");
  c_write: cover property ($fell(write_busy_o) && !abrt_reg);
  c_abort: cover property (write_busy_o && ext_reset);
  c_ctrl_read: cover property (ctrl_rd && rdata[4]);
endmodule : deac_array_properties
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench: APB master on the core side, array block across the port.
// Assumes zero-wait APB answers and a shortened power-up wait.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import deac_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic code_protect_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic ext_reset_i = 1'b0;
  logic wdt_reset_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rd_word;
  logic pready_o, pslverr_o, write_busy_o, programmer_block_o;
  logic [7:0] mem [64];
  logic [7:0] a;
  logic [7:0] d;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int q [$];
  deac_sfr_if deac_sfr_if_inst ();
  deac_array #(.POWERUP_WAIT(16)) deac_array_inst (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .code_protect_i(code_protect_i), .sfr(deac_sfr_if_inst), .write_busy_o(write_busy_o),
    .programmer_block_o(programmer_block_o));
  deac_core deac_core_inst (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_reset_i(ext_reset_i),
    .wdt_reset_i(wdt_reset_i), .sfr(deac_sfr_if_inst));
  deac_array_properties deac_array_properties_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .wr_en(deac_sfr_if_inst.wr_en), .rd_en(deac_sfr_if_inst.rd_en), .addr(deac_sfr_if_inst.addr),
    .wdata(deac_sfr_if_inst.wdata), .rdata(deac_sfr_if_inst.rdata),
    .ext_reset(deac_sfr_if_inst.ext_reset), .wdt_reset(deac_sfr_if_inst.wdt_reset),
    .write_busy_o(write_busy_o));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic conclude();
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  // Eight full write cycles of some 800 clocks each, plus two cut short, fit well inside this ceiling.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= adr;
    pwdata_i <= dat;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 100) begin
      errors++;
    end
    rd_word = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic nv_start(input logic [7:0] adr, input logic [7:0] dat, input logic [7:0] ctl);
    apb(1'b1, CMD_ADDR_OFS, {24'h0, adr});
    apb(1'b1, CMD_DATA_OFS, {24'h0, dat});
    apb(1'b1, CMD_CTRL_OFS, {24'h0, ctl});
    // The core needs six strokes to deliver a write command.
    repeat (8) @(posedge clk_i);
  endtask : nv_start
  task automatic wait_idle();
    int n;
    n = 0;
    apb(1'b0, CMD_STAT_OFS, 32'h0);
    // Idle means the core has no strokes left and the array write has ended.
    while ((rd_word[8] !== 1'b0 || rd_word[1] !== 1'b0) && n < 600) begin
      n++;
      apb(1'b0, CMD_STAT_OFS, 32'h0);
    end
    if (n == 600) begin
      errors++;
    end
  endtask : wait_idle
  task automatic nv_write(input logic [7:0] adr, input logic [7:0] dat);
    nv_start(adr, dat, 8'h06);
    chk("write busy", 32'(write_busy_o), 32'h1);
    wait_idle();
    chk("done flag", 32'(rd_word[4]), 32'h1);
    chk("launch bit", 32'(rd_word[1]), 32'h0);
    chk("permit kept", 32'(rd_word[2]), 32'h1);
    chk("upper bits", 32'(rd_word[7:5]), 32'h0);
    mem[adr[5:0]] = dat;
    apb(1'b1, CMD_CTRL_OFS, 32'h08);
    apb(1'b0, CMD_STAT_OFS, 32'h0);
    chk("done cleared", 32'(rd_word[4]), 32'h0);
  endtask : nv_write
  task automatic nv_read(input logic [7:0] adr);
    nv_start(adr, 8'h00, 8'h01);
    wait_idle();
    apb(1'b0, CMD_RDATA_OFS, 32'h0);
    chk("read data", 32'(rd_word[7:0]), 32'(mem[adr[5:0]]));
  endtask : nv_read
  initial begin
    void'($urandom(32'hb7f2b7ff));
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    apb(1'b0, CMD_STAT_OFS, 32'h0);
    chk("status after reset", 32'(rd_word[8:0]), 32'h0);
    nv_start(8'h05, 8'h3c, 8'h02);
    chk("busy without permit", 32'(write_busy_o), 32'h0);
    wait_idle();
    chk("done without permit", 32'(rd_word[4]), 32'h0);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? ARRAY_LAST : 8'($urandom_range(63));
      d = 8'($urandom);
      code_protect_i <= (i > 2);
      nv_write(a, d);
      chk("programmer block", 32'(programmer_block_o), 32'(i > 2));
      q.push_back(int'(a));
    end
    // Each location is read twice so a stale data register would show.
    foreach (q[i]) begin
      nv_read(8'(q[i]));
      nv_read(8'(q[i]));
    end
    for (int k = 0; k < 2; k++) begin
      a = 8'($urandom_range(63));
      nv_start(a, 8'($urandom), 8'h06);
      repeat (100) @(posedge clk_i);
      ext_reset_i <= (k == 0);
      wdt_reset_i <= (k == 1);
      repeat (2) @(posedge clk_i);
      ext_reset_i <= 1'b0;
      wdt_reset_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("busy after abort", 32'(write_busy_o), 32'h0);
      apb(1'b0, CMD_STAT_OFS, 32'h0);
      chk("abort flag", 32'(rd_word[3]), 32'h1);
      nv_write(a, 8'($urandom));
      nv_read(a);
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
